// >>> src/acc_pkg.sv
// Constants for the calibration correction block: coefficient layout,
// register select codes, reset values and the output data rate tables.
// Assumes no other package; every user names items as acc_pkg::name.
package acc_pkg;
    // ==========================================================
    // Coefficient format
    localparam int COEF_W = 24;
    // Gain coefficient is Q1.22, so 1.0 sits at 0x400000 and the top code is just under 2.0
    localparam int GAIN_FRAC = 22;
    localparam logic [23:0] COEF_RESET = 24'h000000;
    localparam logic [23:0] GAIN_UNITY = 24'h400000;
    localparam logic signed [23:0] DATA_MAX = 24'sh7FFFFF;
    localparam logic signed [23:0] DATA_MIN = -24'sh800000;

    // ==========================================================
    // Register select codes on the parallel register port
    localparam logic [1:0] SEL_SELF_OFFSET = 2'h0;
    localparam logic [1:0] SEL_SELF_GAIN = 2'h1;
    localparam logic [1:0] SEL_SYSTEM_OFFSET = 2'h2;
    localparam logic [1:0] SEL_SYSTEM_GAIN = 2'h3;

    // ==========================================================
    // Unipolar range doubling, as a left shift
    localparam int UNIPOLAR_SHIFT = 1;

    // ==========================================================
    // Output data rates in milli-samples per second, indexed by rate code
    localparam int RATE_W = 20;
    localparam logic [19:0] SINGLE_RATE_LF0 [0:7] = '{20'h003E8, 20'h009C4, 20'h01388, 20'h02710,
                                                      20'h03A98, 20'h07530, 20'h0EA60, 20'h1D4C0};
    localparam logic [19:0] SINGLE_RATE_LF1 [0:7] = '{20'h00341, 20'h00820, 20'h0104A, 20'h0208A,
                                                      20'h030D4, 20'h061A8, 20'h0C350, 20'h186A0};
    // Continuous rates exist for the upper four codes only
    localparam logic [19:0] CONT_RATE_LF0 [0:3] = '{20'h0EA60, 20'h1D4C0, 20'h3A980, 20'h75300};
    localparam logic [19:0] CONT_RATE_LF1 [0:3] = '{20'h0C350, 20'h186A0, 20'h30D40, 20'h61A80};
    localparam logic [19:0] RATE_NONE = 20'h00000;
endpackage

// >>> src/acc_gain_stage.sv
// One gain correction stage: signed multiply by a Q1.22 coefficient,
// with saturation, or a straight pass-through when bypassed.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module acc_gain_stage #(
    parameter int W = acc_pkg::COEF_W,
    parameter int FRAC = acc_pkg::GAIN_FRAC
) (
    input wire logic signed [W-1:0] din,
    input wire logic signed [W-1:0] coef,
    input wire logic bypass,
    output logic signed [W-1:0] dout
);
    // ==========================================================
    // Multiply and rescale
    logic signed [2*W-1:0] product;
    logic signed [2*W-1:0] scaled;
    logic signed [W-1:0] sat_max;
    logic signed [W-1:0] sat_min;

    always_comb begin
        sat_max = {1'b0, {(W-1){1'b1}}};
        sat_min = {1'b1, {(W-1){1'b0}}};
        product = din * coef;
        // Arithmetic shift truncates toward minus infinity; error stays well inside 2 LSB
        scaled = product >>> FRAC;
        if (bypass) begin
            dout = din;
        // Concatenations are unsigned; the cast keeps the compare signed
        end else if (scaled > $signed({{W{sat_max[W-1]}}, sat_max})) begin
            dout = sat_max;
        end else if (scaled < $signed({{W{sat_min[W-1]}}, sat_min})) begin
            dout = sat_min;
        end else begin
            dout = scaled[W-1:0];
        end
    end
endmodule // acc_gain_stage

// >>> src/acc_calibration_correction.sv
// Calibration correction path and coefficient storage of a delta-sigma
// converter, plus the output data rate decode.
// Assumes the serial register framing sits outside and presents one
// decoded register access per cycle on reg_sel/reg_we/reg_wdata, and
// that the calibration sequencer outside drives the cal_* inputs.
//
// Functional notes
// [RQ1] System gain register, 24 bits, read/write
// [RQ2] All coefficients are two's complement values
// [RQ3] System gain kept until rewrite or calibration
// [RQ4] System gain scales unless its disable set
// [RQ5] System gain factor up to 2x, small error
// [RQ6] Self offset register kept until rewrite/calibration
// [RQ7] Self offset subtracted unless its disable set
// [RQ8] Self offset first, before gains and doubling
// [RQ9] Self gain writes dropped during calibration
// [RQ10] Self gain scales before system stages, 2x
// [RQ11] Line select 0 single-cycle rates 1..120
// [RQ12] Continuous rates only for codes 100..111
// [RQ13] Line select 1 rates 0.833..100, continuous 50..400
// [RQ14] System offset after self stages, before gain
// [RQ15] Digital gain applied to final corrected result
// [RQ16] Out-of-range results saturate, never wrap
// [RQ17] Disabled stage passes data through unchanged
`timescale 1ns/1ns
module acc_calibration_correction #(
    parameter int W = acc_pkg::COEF_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [1:0] reg_sel,
    input wire logic reg_we,
    input wire logic [W-1:0] reg_wdata,
    output logic [W-1:0] reg_rdata,
    input wire logic self_offset_disable,
    input wire logic self_gain_disable,
    input wire logic system_offset_disable,
    input wire logic system_gain_disable,
    input wire logic unipolar_mode,
    input wire logic [2:0] digital_gain_code,
    input wire logic line_frequency_select,
    input wire logic [2:0] rate_code,
    input wire logic cal_active,
    input wire logic self_cal_load,
    input wire logic [W-1:0] self_cal_offset,
    input wire logic [W-1:0] self_cal_gain,
    input wire logic sys_cal_load,
    input wire logic [W-1:0] sys_cal_offset,
    input wire logic [W-1:0] sys_cal_gain,
    input wire logic raw_valid,
    input wire logic [W-1:0] raw_data,
    output logic corr_valid,
    output logic [W-1:0] corr_data,
    output logic [acc_pkg::RATE_W-1:0] single_rate_msps,
    output logic [acc_pkg::RATE_W-1:0] cont_rate_msps,
    output logic cont_available
);
    // ==========================================================
    // Saturating narrowing from the wide working width
    localparam int XW = 32;

    function automatic logic signed [W-1:0] sat_narrow(input logic signed [XW-1:0] v);
        logic signed [XW-1:0] hi;
        logic signed [XW-1:0] lo;
        hi = XW'(acc_pkg::DATA_MAX);
        lo = XW'(acc_pkg::DATA_MIN);
        if (v > hi) begin
            sat_narrow = acc_pkg::DATA_MAX; // RQ16
        end else if (v < lo) begin
            sat_narrow = acc_pkg::DATA_MIN; // RQ16
        end else begin
            sat_narrow = v[W-1:0];
        end
    endfunction

    // ==========================================================
    // Sign extension into the working width
    function automatic logic signed [XW-1:0] widen(input logic signed [W-1:0] v);
        widen = {{(XW-W){v[W-1]}}, v};
    endfunction

    // ==========================================================
    // Coefficient registers
    logic [W-1:0] self_offset_coefficient_reg;
    logic [W-1:0] self_offset_coefficient_next;
    logic [W-1:0] self_gain_coefficient_reg;
    logic [W-1:0] self_gain_coefficient_next;
    logic [W-1:0] system_offset_coefficient_reg;
    logic [W-1:0] system_offset_coefficient_next;
    logic [W-1:0] system_gain_coefficient_reg;
    logic [W-1:0] system_gain_coefficient_next;
    // Read-back copy
    logic [W-1:0] rdata_reg;
    logic [W-1:0] rdata_next;

    always_comb begin
        self_offset_coefficient_next = self_offset_coefficient_reg;
        self_gain_coefficient_next = self_gain_coefficient_reg;
        system_offset_coefficient_next = system_offset_coefficient_reg;
        system_gain_coefficient_next = system_gain_coefficient_reg;
        // Host writes first; a calibration result in the same cycle wins
        if (reg_we) begin
            case (reg_sel)
                acc_pkg::SEL_SELF_OFFSET: begin
                    self_offset_coefficient_next = reg_wdata; // RQ6
                end
                acc_pkg::SEL_SELF_GAIN: begin
                    // Dropped silently; the host gets no error flag
                    if (!cal_active) begin
                        self_gain_coefficient_next = reg_wdata; // RQ9
                    end
                end
                acc_pkg::SEL_SYSTEM_OFFSET: begin
                    system_offset_coefficient_next = reg_wdata;
                end
                acc_pkg::SEL_SYSTEM_GAIN: begin
                    system_gain_coefficient_next = reg_wdata; // RQ1 RQ3
                end
                default: begin
                    self_offset_coefficient_next = self_offset_coefficient_reg;
                end
            endcase
        end
        if (self_cal_load) begin
            self_offset_coefficient_next = self_cal_offset; // RQ6
            self_gain_coefficient_next = self_cal_gain; // RQ9
        end
        if (sys_cal_load) begin
            system_offset_coefficient_next = sys_cal_offset;
            system_gain_coefficient_next = sys_cal_gain; // RQ3
        end
        // Read data is a registered copy, so it settles one cycle after reg_sel
        case (reg_sel)
            acc_pkg::SEL_SELF_OFFSET: rdata_next = self_offset_coefficient_reg;
            acc_pkg::SEL_SELF_GAIN: rdata_next = self_gain_coefficient_reg;
            acc_pkg::SEL_SYSTEM_OFFSET: rdata_next = system_offset_coefficient_reg;
            acc_pkg::SEL_SYSTEM_GAIN: rdata_next = system_gain_coefficient_reg; // RQ1
            default: rdata_next = acc_pkg::COEF_RESET;
        endcase
    end

    // ==========================================================
    // Coefficient and read-back registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            self_offset_coefficient_reg <= acc_pkg::COEF_RESET;
            self_gain_coefficient_reg <= acc_pkg::COEF_RESET;
            system_offset_coefficient_reg <= acc_pkg::COEF_RESET;
            system_gain_coefficient_reg <= acc_pkg::COEF_RESET;
            rdata_reg <= acc_pkg::COEF_RESET;
        end else begin
            self_offset_coefficient_reg <= self_offset_coefficient_next;
            self_gain_coefficient_reg <= self_gain_coefficient_next;
            system_offset_coefficient_reg <= system_offset_coefficient_next;
            system_gain_coefficient_reg <= system_gain_coefficient_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // Read-back port
    assign reg_rdata = rdata_reg;

    // ==========================================================
    // Correction chain, in fixed order
    logic signed [W-1:0] after_self_offset;
    logic signed [W-1:0] after_self_gain;
    logic signed [W-1:0] after_system_offset;
    logic signed [W-1:0] after_system_gain;

    // ==========================================================
    // Self offset stage
    // All coefficients are taken as signed values whatever the output format
    always_comb begin
        if (self_offset_disable) begin
            after_self_offset = raw_data; // RQ17
        end else begin
            after_self_offset = sat_narrow(widen(raw_data) - widen(self_offset_coefficient_reg)); // RQ7 RQ8 RQ2
        end
    end

    // ==========================================================
    // Self gain stage
    acc_gain_stage #(
        .W(W),
        .FRAC(acc_pkg::GAIN_FRAC)
    ) u_self_gain (
        .din(after_self_offset),
        .coef(self_gain_coefficient_reg),
        .bypass(self_gain_disable),
        .dout(after_self_gain)
    ); // RQ10 RQ17

    // ==========================================================
    // System offset stage
    always_comb begin
        if (system_offset_disable) begin
            after_system_offset = after_self_gain; // RQ17
        end else begin
            after_system_offset = sat_narrow(widen(after_self_gain) - widen(system_offset_coefficient_reg)); // RQ14
        end
    end

    // ==========================================================
    // System gain stage
    acc_gain_stage #(
        .W(W),
        .FRAC(acc_pkg::GAIN_FRAC)
    ) u_system_gain (
        .din(after_system_offset),
        .coef(system_gain_coefficient_reg),
        .bypass(system_gain_disable),
        .dout(after_system_gain)
    ); // RQ4 RQ5 RQ17

    // ==========================================================
    // Range doubling, digital gain and the output register
    logic signed [W-1:0] after_range;
    logic signed [XW-1:0] gain_wide;
    logic corr_valid_reg;
    logic corr_valid_next;
    logic [W-1:0] corr_data_reg;
    logic [W-1:0] corr_data_next;

    always_comb begin
        // Doubling comes after every offset so that offsets are in input units
        if (unipolar_mode) begin
            after_range = sat_narrow(widen(after_system_gain) <<< acc_pkg::UNIPOLAR_SHIFT); // RQ8
        end else begin
            after_range = after_system_gain;
        end
        // Shift by at most 7 into 32 bits cannot overflow before the clamp
        gain_wide = widen(after_range) <<< digital_gain_code; // RQ15
        // Holding the last result lets a slow reader still fetch it
        corr_valid_next = raw_valid;
        corr_data_next = corr_data_reg;
        if (raw_valid) begin
            corr_data_next = sat_narrow(gain_wide); // RQ16
        end
    end

    // ==========================================================
    // Output register
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            corr_valid_reg <= 1'b0;
            corr_data_reg <= acc_pkg::COEF_RESET;
        end else begin
            corr_valid_reg <= corr_valid_next;
            corr_data_reg <= corr_data_next;
        end
    end

    // ==========================================================
    // Result ports
    assign corr_valid = corr_valid_reg;
    assign corr_data = corr_data_reg;

    // ==========================================================
    // Output data rate decode
    logic [acc_pkg::RATE_W-1:0] single_rate_reg;
    logic [acc_pkg::RATE_W-1:0] single_rate_next;
    logic [acc_pkg::RATE_W-1:0] cont_rate_reg;
    logic [acc_pkg::RATE_W-1:0] cont_rate_next;
    logic cont_available_reg;
    logic cont_available_next;

    always_comb begin
        if (line_frequency_select) begin
            single_rate_next = acc_pkg::SINGLE_RATE_LF1[rate_code]; // RQ13
        end else begin
            single_rate_next = acc_pkg::SINGLE_RATE_LF0[rate_code]; // RQ11
        end
        // Level decode; a new code shows one cycle later
        // Lower four codes have no continuous mode
        cont_available_next = rate_code[2]; // RQ12
        if (!rate_code[2]) begin
            cont_rate_next = acc_pkg::RATE_NONE; // RQ12
        end else if (line_frequency_select) begin
            cont_rate_next = acc_pkg::CONT_RATE_LF1[rate_code[1:0]]; // RQ13
        end else begin
            cont_rate_next = acc_pkg::CONT_RATE_LF0[rate_code[1:0]]; // RQ12
        end
    end

    // ==========================================================
    // Rate registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            single_rate_reg <= acc_pkg::RATE_NONE;
            cont_rate_reg <= acc_pkg::RATE_NONE;
            cont_available_reg <= 1'b0;
        end else begin
            single_rate_reg <= single_rate_next;
            cont_rate_reg <= cont_rate_next;
            cont_available_reg <= cont_available_next;
        end
    end

    // ==========================================================
    // Rate ports
    assign single_rate_msps = single_rate_reg;
    assign cont_rate_msps = cont_rate_reg;
    assign cont_available = cont_available_reg;
endmodule // acc_calibration_correction

// >>> bench/acc_props.sv
// Checker for the calibration correction block, on its top ports only.
// Assumes one clock domain and binding onto acc_calibration_correction.
`timescale 1ns/1ns
module acc_props #(
    parameter int W = 24
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [1:0] reg_sel,
    input wire logic reg_we,
    input wire logic [W-1:0] reg_wdata,
    input wire logic [W-1:0] reg_rdata,
    input wire logic self_offset_disable,
    input wire logic self_gain_disable,
    input wire logic system_offset_disable,
    input wire logic system_gain_disable,
    input wire logic unipolar_mode,
    input wire logic [2:0] digital_gain_code,
    input wire logic [2:0] rate_code,
    input wire logic cal_active,
    input wire logic self_cal_load,
    input wire logic sys_cal_load,
    input wire logic [W-1:0] sys_cal_gain,
    input wire logic raw_valid,
    input wire logic [W-1:0] raw_data,
    input wire logic corr_valid,
    input wire logic [W-1:0] corr_data,
    input wire logic [19:0] single_rate_msps,
    input wire logic [19:0] cont_rate_msps,
    input wire logic cont_available
);
    // ==========================================================
    // Data path timing
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_valid_latency: assert property (raw_valid |=> corr_valid)
        else $error("corr_valid missing one cycle after raw_valid");
    a_valid_pulse: assert property (!raw_valid |=> !corr_valid and $stable(corr_data))
        else $error("corr output changed without a sample");
    a_all_bypass: assert property (raw_valid && self_offset_disable && self_gain_disable
        && system_offset_disable && system_gain_disable && !unipolar_mode && digital_gain_code == 3'h0
        |=> corr_data == $past(raw_data))
        else $error("bypassed path altered the sample");
    // ==========================================================
    // Rate decode; continuous rate is four times the single rate
    a_cont_avail: assert property (nrst |=> cont_available == $past(rate_code[2]))
        else $error("continuous availability wrong for rate code");
    a_cont_rate: assert property (cont_rate_msps ==
        (cont_available ? {single_rate_msps[17:0], 2'h0} : 20'h00000))
        else $error("continuous rate inconsistent");
    // ==========================================================
    // Coefficient storage
    a_sg_write_read: assert property ((reg_we && reg_sel == 2'h3 && !sys_cal_load) ##1
        (reg_sel == 2'h3 && !reg_we && !sys_cal_load) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("system gain readback differs from write");
    a_sg_cal_load: assert property (sys_cal_load ##1 (reg_sel == 2'h3 && !reg_we && !sys_cal_load)
        |=> reg_rdata == $past(sys_cal_gain, 2))
        else $error("system calibration did not replace gain");
    a_self_gain_lock: assert property ((cal_active && reg_we && reg_sel == 2'h1 && !self_cal_load) ##1
        (reg_sel == 2'h1 && !reg_we && !self_cal_load) |=> reg_rdata == $past(reg_rdata))
        else $error("self gain written during calibration");
    c_unipolar: cover property (raw_valid && unipolar_mode);
    c_sys_load: cover property (sys_cal_load);
    c_locked_write: cover property (cal_active && reg_we);
endmodule // acc_props
bind acc_calibration_correction acc_props #(.W(W)) u_props (.sys_clk(sys_clk), .nrst(nrst),
    .reg_sel(reg_sel), .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .self_offset_disable(self_offset_disable), .self_gain_disable(self_gain_disable),
    .system_offset_disable(system_offset_disable), .system_gain_disable(system_gain_disable),
    .unipolar_mode(unipolar_mode), .digital_gain_code(digital_gain_code), .rate_code(rate_code),
    .cal_active(cal_active), .self_cal_load(self_cal_load), .sys_cal_load(sys_cal_load),
    .sys_cal_gain(sys_cal_gain), .raw_valid(raw_valid), .raw_data(raw_data), .corr_valid(corr_valid),
    .corr_data(corr_data), .single_rate_msps(single_rate_msps), .cont_rate_msps(cont_rate_msps),
    .cont_available(cont_available));

// >>> bench/acc_host_model.sv
// Host model: register accesses on the parallel register port.
// Assumes the bench calls one task at a time, never overlapping.
`timescale 1ns/1ns
module acc_host_model (
    input wire logic sys_clk,
    output logic [1:0] reg_sel,
    output logic reg_we,
    output logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata
);
    initial begin
        reg_sel = 2'h0;
        reg_we = 1'b0;
        reg_wdata = 24'h000000;
    end
    // ==========================================================
    // Idle data is the inverse, so a stale word never looks valid
    task automatic write_reg(input logic [1:0] sel, input logic [23:0] data);
        @(posedge sys_clk);
        reg_sel <= sel;
        reg_we <= 1'b1;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_we <= 1'b0;
        reg_wdata <= ~data;
    endtask
    // Readback lags the select by one edge
    task automatic read_reg(input logic [1:0] sel, output logic [23:0] data);
        @(posedge sys_clk);
        reg_sel <= sel;
        @(posedge sys_clk);
        // Taken just after the latching edge, clear of the next launch
        #1;
        data = reg_rdata;
    endtask
endmodule // acc_host_model

// >>> bench/tb.sv
// Bench: coefficient access, corrected data rows, rate decode, calibration.
// Assumes the checker binds itself; the host model owns the register port.
`timescale 1ns/1ns
module tb;
    typedef struct {logic [23:0] raw; logic [3:0] dis; logic uni; logic [2:0] dg;} acc_row_t;
    logic sys_clk = 1'b0, nrst = 1'b0, reg_we, corr_valid, cont_available;
    logic [1:0] reg_sel;
    logic [23:0] reg_wdata, reg_rdata, corr_data, v;
    logic [19:0] single_rate_msps, cont_rate_msps;
    logic self_offset_disable = 1'b1, self_gain_disable = 1'b1, system_offset_disable = 1'b1;
    logic system_gain_disable = 1'b1, unipolar_mode = 1'b0, line_frequency_select = 1'b0;
    logic cal_active = 1'b0, self_cal_load = 1'b0, sys_cal_load = 1'b0, raw_valid = 1'b0;
    logic [2:0] digital_gain_code = 3'h0, rate_code = 3'h0;
    logic [23:0] self_cal_offset = 24'h000000, self_cal_gain = 24'h000000, raw_data = 24'h000000;
    logic [23:0] sys_cal_offset = 24'h000000, sys_cal_gain = 24'h000000;
    logic [23:0] coef [4] = '{24'h000100, 24'h480000, 24'hFFFF80, 24'h3C0000};
    int bad_count = 0, compares = 0;
    int sr [2][8] = '{'{1000, 2500, 5000, 10000, 15000, 30000, 60000, 120000},
                      '{833, 2080, 4170, 8330, 12500, 25000, 50000, 100000}};
    acc_row_t rows [11] = '{'{24'h123456, 4'hF, 1'b0, 3'h0}, '{24'h123456, 4'h7, 1'b0, 3'h0},
        '{24'h123456, 4'hB, 1'b0, 3'h0}, '{24'h123456, 4'hD, 1'b0, 3'h0}, '{24'h123456, 4'hE, 1'b0, 3'h0},
        '{24'hF00000, 4'h0, 1'b0, 3'h0}, '{24'h7FFFF0, 4'h3, 1'b0, 3'h0}, '{24'h200000, 4'h0, 1'b1, 3'h0},
        '{24'h001234, 4'h0, 1'b0, 3'h3}, '{24'h900000, 4'h0, 1'b0, 3'h7}, '{24'h800000, 4'h7, 1'b0, 3'h0}};
    acc_calibration_correction u_dut (.*);
    acc_host_model u_host (.*);
    always #5 sys_clk = ~sys_clk;
    // ==========================================================
    // Checking and reference model
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic signed [23:0] sat(input longint x);
        if (x > 64'sh7FFFFF) return 24'sh7FFFFF;
        if (x < -64'sh800000) return -24'sh800000;
        return x[23:0];
    endfunction
    // Every stage clamps, so a wrap anywhere shows in the result
    function automatic logic [23:0] exp_corr(input acc_row_t r);
        longint x;
        x = $signed(r.raw);
        if (!r.dis[3]) x = sat(x - $signed(coef[0]));
        if (!r.dis[2]) x = sat((x * $signed(coef[1])) >>> 22);
        if (!r.dis[1]) x = sat(x - $signed(coef[2]));
        if (!r.dis[0]) x = sat((x * $signed(coef[3])) >>> 22);
        if (r.uni) x = sat(x * 2);
        return sat(x <<< r.dg);
    endfunction
    task automatic drive(input acc_row_t r, input logic vld);
        raw_valid <= vld;
        raw_data <= r.raw;
        {self_offset_disable, self_gain_disable, system_offset_disable, system_gain_disable} <= r.dis;
        unipolar_mode <= r.uni;
        digital_gain_code <= r.dg;
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check(corr_data, 24'h000000);
        check({4'h0, single_rate_msps}, 24'h000000);
        check({3'h0, cont_available, cont_rate_msps}, 24'h000000);
        check({23'h0, corr_valid}, 24'h000000);
        @(posedge sys_clk);
        nrst <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            u_host.read_reg(s[1:0], v);
            check(v, 24'h000000);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        final_report();
    end
    // ==========================================================
    // Main sequence
    initial begin
        do_reset();
        for (int s = 0; s < 4; s++) begin
            u_host.write_reg(s[1:0], coef[s]);
            u_host.read_reg(s[1:0], v);
            check(v, coef[s]);
        end
        // Back to back samples: row i is checked while row i+1 is sent
        foreach (rows[i]) begin
            @(posedge sys_clk);
            drive(rows[i], 1'b1);
            #1;
            if (i > 0) check(corr_data, exp_corr(rows[i-1]));
            if (i > 0) check({23'h0, corr_valid}, 24'h000001);
        end
        @(posedge sys_clk);
        drive(rows[0], 1'b0);
        #1;
        check(corr_data, exp_corr(rows[10]));
        @(posedge sys_clk);
        #1;
        check({23'h0, corr_valid}, 24'h000000);
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            line_frequency_select <= i[3];
            rate_code <= i[2:0];
            @(posedge sys_clk);
            #1;
            check({4'h0, single_rate_msps}, 24'(sr[i / 8][i % 8]));
            check({4'h0, cont_rate_msps}, i[2] ? 24'(4 * sr[i / 8][i % 8]) : 24'h000000);
            check({23'h0, cont_available}, {23'h0, i[2]});
        end
        cal_active <= 1'b1;
        u_host.write_reg(2'h1, 24'h111111);
        cal_active <= 1'b0;
        u_host.read_reg(2'h1, v);
        check(v, coef[1]);
        u_host.read_reg(2'h3, v);
        check(v, coef[3]);
        @(posedge sys_clk);
        self_cal_load <= 1'b1;
        sys_cal_load <= 1'b1;
        {self_cal_offset, self_cal_gain} <= {24'hFFFF00, 24'h3FFFFF};
        {sys_cal_offset, sys_cal_gain} <= {24'h000040, 24'h2AAAAA};
        @(posedge sys_clk);
        self_cal_load <= 1'b0;
        sys_cal_load <= 1'b0;
        coef = '{24'hFFFF00, 24'h3FFFFF, 24'h000040, 24'h2AAAAA};
        for (int s = 0; s < 4; s++) begin
            u_host.read_reg(s[1:0], v);
            check(v, coef[s]);
        end
        do_reset();
        final_report();
    end
endmodule // tb
